// ---- rtl/cspc_core_sfr.v ----
// special function register bank, data pointers, rate and stretch control
`timescale 1ns/1ps
`include "cspc_defines.vh"
module cspc_core_sfr #(
    parameter LEGACY_DIV = `CSPC_LEGACY_DIV,
    parameter PM_DIV = `CSPC_PM_DIV
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire sfr_direct_i,
    input wire sfr_bit_i,
    input wire [7:0] sfr_addr_i,
    input wire [2:0] sfr_bit_sel_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    output wire sfr_hit_o,
    input wire xmove_req_i,
    input wire irq_pending_i,
    input wire ext_access_i,
    output reg [15:0] xmove_addr_o,
    output wire xmove_busy_o,
    output wire xmove_done_o,
    output wire cycle_adv_o,
    output wire [2:0] timer_tick_o,
    output wire ale_enable_o,
    output wire [31:0] port_latch_o,
    output wire [7:0] stack_ptr_o
);
    reg [7:0] stack_reg;
    reg [7:0] pctl_reg;
    reg [7:0] clk_ctrl_reg;
    reg [7:0] pmr_reg;
    wire [31:0] ptr_flat;
    wire [47:0] timer_flat;
    reg [3:0] pre12_reg;
    reg [9:0] pmdiv_reg;
    reg [3:0] xcnt_reg;
    reg xbusy_reg;
    reg [7:0] cur;
    reg [7:0] wval;
    wire direct_ok;
    wire wr_en;
    wire bit_ok;
    wire [2:0] stretch;
    wire [15:0] act_ptr;
    wire [15:0] adj_ptr;
    wire tick12;
    wire move_end;
    wire move_take;

    // indirect accesses never reach this space, addr top bit marks sfr space
    assign direct_ok = sfr_direct_i & sfr_addr_i[7];
    // bit ops only on column-0 registers, others ignore them
    assign bit_ok = ~sfr_bit_i | (sfr_addr_i[2:0] == 3'h0);
    assign wr_en = sfr_wr_i & direct_ok & bit_ok;
    assign sfr_hit_o = direct_ok & bit_ok & (sfr_wr_i | sfr_rd_i);

    // current register value for read and read-modify-write of bits
    always @* begin
        cur = 8'h00;
        case (sfr_addr_i)
            `CSPC_A_PORT0: cur = port_latch_o[7:0];
            `CSPC_A_PORT1: cur = port_latch_o[15:8];
            `CSPC_A_PORT2: cur = port_latch_o[23:16];
            `CSPC_A_PORT3: cur = port_latch_o[31:24];
            `CSPC_A_STACK: cur = stack_reg;
            `CSPC_A_PTR0_LO: cur = ptr_flat[7:0];
            `CSPC_A_PTR0_HI: cur = ptr_flat[15:8];
            `CSPC_A_PTR1_LO: cur = ptr_flat[23:16];
            `CSPC_A_PTR1_HI: cur = ptr_flat[31:24];
            `CSPC_A_PTR_CTRL: cur = pctl_reg;
            `CSPC_A_TL0: cur = timer_flat[7:0];
            `CSPC_A_TH0: cur = timer_flat[15:8];
            `CSPC_A_TL1: cur = timer_flat[23:16];
            `CSPC_A_TH1: cur = timer_flat[31:24];
            `CSPC_A_TL2: cur = timer_flat[39:32];
            `CSPC_A_TH2: cur = timer_flat[47:40];
            `CSPC_A_CLK_CTRL: cur = clk_ctrl_reg;
            `CSPC_A_PMR: cur = pmr_reg;
            default: cur = 8'h00;
        endcase
    end

    // a bit write merges one bit into the current byte
    always @* begin
        wval = sfr_wdata_i;
        if (sfr_bit_i) begin
            wval = cur;
            wval[sfr_bit_sel_i] = sfr_wdata_i[0];
        end
    end

    // registered read data; bit reads return the bit in lane 0
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i & direct_ok & bit_ok) begin
            sfr_rdata_o <= sfr_bit_i ? {7'h00, cur[sfr_bit_sel_i]} : cur;
        end
    end

    // active pointer and its adjusted value, ready for the taking edge
    assign act_ptr = pctl_reg[`CSPC_PCTL_SEL] ? ptr_flat[31:16] : ptr_flat[15:0];
    assign adj_ptr = pctl_reg[`CSPC_PCTL_DIR] ? act_ptr - 16'h0001
                                              : act_ptr + 16'h0001;
    assign stretch = clk_ctrl_reg[2:0];

    // power management divider; cycle_adv marks each machine cycle
    always @(posedge clk_i) begin
        if (!reset_n_i || !pmr_reg[`CSPC_PMR_PM]) begin
            pmdiv_reg <= 10'h000;
        end else begin
            pmdiv_reg <= (pmdiv_reg == PM_DIV - 1) ? 10'h000 : pmdiv_reg + 10'h001;
        end
    end
    assign cycle_adv_o = ~pmr_reg[`CSPC_PMR_PM] | (pmdiv_reg == PM_DIV - 1);

    // stretch counter; base move is two machine cycles, stretch adds more
    // the stretch field counts 0..7, mapped onto 0..10 like a coarse table
    function [3:0] extra_cycles;
        input [2:0] s;
        begin
            case (s)
                3'h0: extra_cycles = 4'h0;
                3'h1: extra_cycles = 4'h1;
                3'h2: extra_cycles = 4'h2;
                3'h3: extra_cycles = 4'h3;
                3'h4: extra_cycles = 4'h4;
                3'h5: extra_cycles = 4'h6;
                3'h6: extra_cycles = 4'h8;
                default: extra_cycles = `CSPC_MAX_STRETCH;
            endcase
        end
    endfunction
    assign move_end = xbusy_reg & cycle_adv_o & (xcnt_reg == 4'h0);
    // a move is taken only on an advancing idle cycle
    assign move_take = xmove_req_i & cycle_adv_o & ~xbusy_reg;
    assign xmove_busy_o = xbusy_reg;
    assign xmove_done_o = move_end;

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            xbusy_reg <= 1'b0;
            xcnt_reg <= 4'h0;
            xmove_addr_o <= 16'h0000;
        end else if (!xbusy_reg) begin
            if (xmove_req_i & cycle_adv_o) begin
                xbusy_reg <= 1'b1;
                xmove_addr_o <= act_ptr;
                // first cycle here, second when count hits zero
                xcnt_reg <= extra_cycles(stretch);
            end
        end else if (move_end) begin
            xbusy_reg <= 1'b0;
        end else if (cycle_adv_o) begin
            xcnt_reg <= xcnt_reg - 4'h1;
        end
    end

    // with the ale-off bit set, ale held off unless an external access or a move is in flight
    assign ale_enable_o = ~pmr_reg[`CSPC_PMR_ALE_OFF] | ext_access_i | xbusy_reg;

    // legacy prescaler so timers keep the old intervals
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            pre12_reg <= 4'h0;
        end else begin
            pre12_reg <= (pre12_reg == LEGACY_DIV - 1) ? 4'h0 : pre12_reg + 4'h1;
        end
    end
    assign tick12 = (pre12_reg == LEGACY_DIV - 1);

    genvar g;

    // port latches; one per port, spaced 10h apart in the sfr map
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_port
            localparam [7:0] PORT_A = (g == 0) ? `CSPC_A_PORT0 :
                                      (g == 1) ? `CSPC_A_PORT1 :
                                      (g == 2) ? `CSPC_A_PORT2 : `CSPC_A_PORT3;
            reg [7:0] latch_reg;
            // the latch holds what software wrote, not what the pin shows
            always @(posedge clk_i) begin
                if (!reset_n_i) begin
                    latch_reg <= `CSPC_RST_PORT;
                end else if (wr_en && (sfr_addr_i == PORT_A)) begin
                    latch_reg <= wval;
                end
            end
            assign port_latch_o[8 * g +: 8] = latch_reg;
        end
    endgenerate

    // data pointer pair; the active one is adjusted once per taken move
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ptr
            localparam [7:0] LO_A = (g == 0) ? `CSPC_A_PTR0_LO : `CSPC_A_PTR1_LO;
            localparam [7:0] HI_A = (g == 0) ? `CSPC_A_PTR0_HI : `CSPC_A_PTR1_HI;
            reg [15:0] value_reg;
            reg [15:0] value_next;
            wire is_active = (pctl_reg[`CSPC_PCTL_SEL] == g);
            // software writes to a half land after the adjust, so they win
            always @* begin
                value_next = value_reg;
                if (move_take && pctl_reg[`CSPC_PCTL_ADJ] && is_active) begin
                    value_next = adj_ptr;
                end
                if (wr_en && (sfr_addr_i == LO_A)) begin
                    value_next[7:0] = wval;
                end
                if (wr_en && (sfr_addr_i == HI_A)) begin
                    value_next[15:8] = wval;
                end
            end
            // pointers clear on reset so the first move targets address zero
            always @(posedge clk_i) begin
                if (!reset_n_i) begin
                    value_reg <= 16'h0000;
                end else begin
                    value_reg <= value_next;
                end
            end
            assign ptr_flat[16 * g +: 16] = value_reg;
        end
    endgenerate

    // three timers; halves are not latched as a pair, so reads can tear
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_tmr
            localparam [7:0] LO_A = (g == 0) ? `CSPC_A_TL0 :
                                    (g == 1) ? `CSPC_A_TL1 : `CSPC_A_TL2;
            localparam [7:0] HI_A = (g == 0) ? `CSPC_A_TH0 :
                                    (g == 1) ? `CSPC_A_TH1 : `CSPC_A_TH2;
            reg [15:0] count_reg;
            reg [15:0] count_next;
            // per-timer rate select: fast bit ticks every clock
            assign timer_tick_o[g] = clk_ctrl_reg[`CSPC_CK_T0 + g] | tick12;
            // a written half replaces the ticked half in the same cycle
            always @* begin
                count_next = count_reg;
                if (timer_tick_o[g]) begin
                    count_next = count_reg + 16'h0001;
                end
                if (wr_en && (sfr_addr_i == LO_A)) begin
                    count_next[7:0] = wval;
                end
                if (wr_en && (sfr_addr_i == HI_A)) begin
                    count_next[15:8] = wval;
                end
            end
            // counters run freely; there is no run bit in this block
            always @(posedge clk_i) begin
                if (!reset_n_i) begin
                    count_reg <= 16'h0000;
                end else begin
                    count_reg <= count_next;
                end
            end
            assign timer_flat[16 * g +: 16] = count_reg;
        end
    endgenerate

    // register writes, pointer select toggle, power management switchback
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            stack_reg <= `CSPC_RST_STACK;
            pctl_reg <= `CSPC_RST_PTR_CTRL;
            clk_ctrl_reg <= `CSPC_RST_CLK_CTRL;
            pmr_reg <= `CSPC_RST_PMR;
        end else begin
            // toggle after a move is taken; adjust sits in the pointer loop
            if (move_take) begin
                if (pctl_reg[`CSPC_PCTL_TOGGLE])
                    pctl_reg[`CSPC_PCTL_SEL] <= ~pctl_reg[`CSPC_PCTL_SEL];
            end
            // switchback drops power management when an interrupt waits
            if (pmr_reg[`CSPC_PMR_SWB] & irq_pending_i)
                pmr_reg[`CSPC_PMR_PM] <= 1'b0;
            // software writes come last, so they win over hardware updates
            if (wr_en) begin
                case (sfr_addr_i)
                    `CSPC_A_STACK: stack_reg <= wval;
                    `CSPC_A_PTR_CTRL: pctl_reg <= wval;
                    `CSPC_A_CLK_CTRL: clk_ctrl_reg <= wval;
                    `CSPC_A_PMR: pmr_reg <= wval;
                    default: ;
                endcase
            end
        end
    end

    assign stack_ptr_o = stack_reg;
endmodule

// ---- rtl/cspc_defines.vh ----
// constants for the core sfr and pointer control block
`ifndef CSPC_DEFINES_VH
`define CSPC_DEFINES_VH
`define CSPC_SFR_BASE 8'h80
`define CSPC_A_PORT0 8'h80
`define CSPC_A_STACK 8'h81
`define CSPC_A_PTR0_LO 8'h82
`define CSPC_A_PTR0_HI 8'h83
`define CSPC_A_PTR1_LO 8'h84
`define CSPC_A_PTR1_HI 8'h85
`define CSPC_A_PTR_CTRL 8'h86
`define CSPC_A_TL0 8'h8A
`define CSPC_A_TL1 8'h8B
`define CSPC_A_TH0 8'h8C
`define CSPC_A_TH1 8'h8D
`define CSPC_A_CLK_CTRL 8'h8E
`define CSPC_A_PORT1 8'h90
`define CSPC_A_PORT2 8'hA0
`define CSPC_A_PORT3 8'hB0
`define CSPC_A_PMR 8'hC4
`define CSPC_A_TL2 8'hCC
`define CSPC_A_TH2 8'hCD
`define CSPC_PCTL_SEL 0
`define CSPC_PCTL_DIR 4
`define CSPC_PCTL_TOGGLE 5
`define CSPC_PCTL_ADJ 6
`define CSPC_CK_T0 3
`define CSPC_PMR_ALE_OFF 2
`define CSPC_PMR_SWB 5
`define CSPC_PMR_PM 6
`define CSPC_RST_PORT 8'hFF
`define CSPC_RST_STACK 8'h07
`define CSPC_RST_PTR_CTRL 8'h04
`define CSPC_RST_CLK_CTRL 8'h01
`define CSPC_RST_PMR 8'h00
`define CSPC_LEGACY_DIV 12
`define CSPC_PM_DIV 1024
`define CSPC_MAX_STRETCH 4'hA
`endif

// ---- tb/cspc_core_sfr_props.sv ----
// concurrent checks on the sfr and pointer control block ports
`timescale 1ns/1ps
module cspc_core_sfr_props (
    input wire clk_i,
    input wire reset_n_i,
    input wire sfr_wr_i,
    input wire sfr_direct_i,
    input wire sfr_bit_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_hit_o,
    input wire xmove_req_i,
    input wire ext_access_i,
    input wire [15:0] xmove_addr_o,
    input wire xmove_busy_o,
    input wire xmove_done_o,
    input wire cycle_adv_o,
    input wire ale_enable_o,
    input wire [31:0] port_latch_o,
    input wire [7:0] stack_ptr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // decode refusals: low space, indirect, bit access off the x0h/x8h column
    low_addr_a: assert property (sfr_addr_i < 8'h80 |-> !sfr_hit_o) else $error("low hit");
    indirect_a: assert property (!sfr_direct_i |-> !sfr_hit_o) else $error("indirect hit");
    bit_col_a: assert property (sfr_bit_i && sfr_addr_i[2:0] != 3'h0 |-> !sfr_hit_o)
        else $error("bit access off column");
    // a move is taken on an advancing idle cycle and is busy next cycle
    move_take_a: assert property (xmove_req_i && !xmove_busy_o && cycle_adv_o |=> xmove_busy_o)
        else $error("move not taken");
    done_end_a: assert property (xmove_done_o |-> xmove_busy_o ##1 !xmove_busy_o)
        else $error("busy after done");
    // the far side relies on a steady address for the whole move
    addr_hold_a: assert property (xmove_busy_o && $past(xmove_busy_o) |-> $stable(xmove_addr_o))
        else $error("address moved");
    ext_strobe_a: assert property (ext_access_i |-> ale_enable_o) else $error("strobe off");
    reset_state_a: assert property ($rose(reset_n_i) |-> cycle_adv_o && ale_enable_o
        && port_latch_o == 32'hFFFFFFFF && stack_ptr_o == 8'h07) else $error("reset state");
    move_c: cover property (xmove_done_o);
    bit_c: cover property (sfr_wr_i && sfr_bit_i && sfr_hit_o);
    ext_c: cover property (ext_access_i && ale_enable_o);
endmodule

// ---- tb/cspc_core_sfr_test.sv ----
// self-checking bench for the sfr and pointer control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module cspc_core_sfr_test;
    typedef struct {logic [7:0] a; logic b; logic [2:0] s; logic d; logic [7:0] w;
        logic h; logic [7:0] r;} cspc_row_t;
    logic clk_i = 1'h0, reset_n_i = 1'h0, wr = 1'h0, rd = 1'h0, dir = 1'h1, bt = 1'h0;
    logic req = 1'h0, irq = 1'h0, ext = 1'h0;
    logic [7:0] addr = 8'h00, wd = 8'h00;
    logic [2:0] sel = 3'h0;
    wire [7:0] rdata, sp, mcnt;
    wire hit, busy, done, adv, ale;
    wire [15:0] xa, ma;
    wire [2:0] tick;
    wire [31:0] ports;
    int checks = 0, miscompares = 0, n;
    // writes first, then refusals, then one timer write: bit write clears bit 3 of the ff port latch
    cspc_row_t rows [11] = '{'{8'h80, 1'h0, 3'h0, 1'h1, 8'h5A, 1'h1, 8'h5A},
        '{8'h81, 1'h0, 3'h0, 1'h1, 8'h30, 1'h1, 8'h30}, '{8'h82, 1'h0, 3'h0, 1'h1, 8'h34, 1'h1, 8'h34},
        '{8'h83, 1'h0, 3'h0, 1'h1, 8'h12, 1'h1, 8'h12}, '{8'h84, 1'h0, 3'h0, 1'h1, 8'hCD, 1'h1, 8'hCD},
        '{8'h85, 1'h0, 3'h0, 1'h1, 8'hAB, 1'h1, 8'hAB}, '{8'hB0, 1'h1, 3'h3, 1'h1, 8'h00, 1'h1, 8'hF7},
        '{8'h20, 1'h0, 3'h0, 1'h1, 8'h11, 1'h0, 8'h00}, '{8'h90, 1'h0, 3'h0, 1'h0, 8'h11, 1'h0, 8'h00},
        '{8'hA1, 1'h1, 3'h1, 1'h1, 8'h00, 1'h0, 8'h00},
        '{8'h8C, 1'h0, 3'h0, 1'h1, 8'h55, 1'h1, 8'h55}};
    always #10 clk_i = ~clk_i;
    cspc_core_sfr #(.PM_DIV(8)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_direct_i(dir), .sfr_bit_i(bt), .sfr_addr_i(addr), .sfr_bit_sel_i(sel),
        .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .xmove_req_i(req),
        .irq_pending_i(irq), .ext_access_i(ext), .xmove_addr_o(xa), .xmove_busy_o(busy),
        .xmove_done_o(done), .cycle_adv_o(adv), .timer_tick_o(tick), .ale_enable_o(ale),
        .port_latch_o(ports), .stack_ptr_o(sp));
    cspc_xmem_model mem (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(xa), .done_i(done),
        .last_addr_o(ma), .moves_o(mcnt));
    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task bound;
        if (n >= 50) begin miscompares++; summarize; end
    endtask
    // one write cycle; the comb hit flag is looked at before the taking edge
    task acc(input [7:0] a, input b, input [2:0] s, input d, input [7:0] w, input h);
        @(negedge clk_i);
        addr = a; bt = b; sel = s; dir = d; wd = w; wr = 1'h1;
        #1 `CHK(hit, h)
        @(negedge clk_i) wr = 1'h0;
    endtask
    task rdb(input [7:0] a);
        @(negedge clk_i);
        addr = a; bt = 1'h0; dir = 1'h1; rd = 1'h1;
        @(negedge clk_i) rd = 1'h0;
    endtask
    // hold the request until busy shows, then count busy cycles
    task mv(input [15:0] ea, input int en);
        @(negedge clk_i) req = 1'h1;
        for (n = 0; n < 50 && busy !== 1'h1; n++) @(negedge clk_i);
        bound;
        req = 1'h0;
        `CHK(xa, ea)
        for (n = 0; n < 50 && busy === 1'h1; n++) @(negedge clk_i);
        bound;
        `CHK(n, en)
    endtask
    task cnt(input int w, input int k);
        n = 0;
        repeat (k) begin @(negedge clk_i); n += (w < 3) ? tick[w] : adv; end
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        reset_n_i = 1'h1;
        foreach (rows[i]) begin
            acc(rows[i].a, rows[i].b, rows[i].s, rows[i].d, rows[i].w, rows[i].h);
            if (rows[i].h) begin rdb(rows[i].a); `CHK(rdata, rows[i].r) end
        end
        `CHK(sp, 8'h30)
        `CHK(ports, 32'hF7FFFF5A)
        acc(8'h8E, 1'h0, 3'h0, 1'h1, 8'h00, 1'h1);
        acc(8'h86, 1'h0, 3'h0, 1'h1, 8'h60, 1'h1);
        mv(16'h1234, 1);
        mv(16'hABCD, 1);
        mv(16'h1235, 1);
        acc(8'h8E, 1'h0, 3'h0, 1'h1, 8'h07, 1'h1);
        mv(16'hABCE, 11);
        `CHK(ma, 16'hABCE)
        `CHK(mcnt, 8'h04)
        cnt(1, 120); `CHK(n, 10)
        acc(8'h8E, 1'h0, 3'h0, 1'h1, 8'h10, 1'h1);
        cnt(1, 120); `CHK(n, 120)
        cnt(0, 120); `CHK(n, 10)
        cnt(3, 50); `CHK(n, 50)
        acc(8'hC4, 1'h0, 3'h0, 1'h1, 8'h04, 1'h1);
        #1 `CHK(ale, 1'h0)
        @(negedge clk_i) ext = 1'h1;
        #1 `CHK(ale, 1'h1)
        acc(8'hC4, 1'h0, 3'h0, 1'h1, 8'h40, 1'h1);
        ext = 1'h0;
        cnt(3, 80); `CHK(n, 10)
        acc(8'hC4, 1'h0, 3'h0, 1'h1, 8'h60, 1'h1);
        irq = 1'h1;
        repeat (20) @(negedge clk_i);
        cnt(3, 16); `CHK(n, 16)
        irq = 1'h0;
        reset_n_i = 1'h0;
        repeat (6) @(negedge clk_i);
        reset_n_i = 1'h1;
        rdb(8'h86); `CHK(rdata, 8'h04)
        rdb(8'h8E); `CHK(rdata, 8'h01)
        `CHK(ports, 32'hFFFFFFFF)
        `CHK(sp, 8'h07)
        mv(16'h0000, 2);
        summarize;
    end
endmodule
bind cspc_core_sfr cspc_core_sfr_props chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .sfr_wr_i(sfr_wr_i), .sfr_direct_i(sfr_direct_i), .sfr_bit_i(sfr_bit_i),
    .sfr_addr_i(sfr_addr_i), .sfr_hit_o(sfr_hit_o), .xmove_req_i(xmove_req_i),
    .ext_access_i(ext_access_i), .xmove_addr_o(xmove_addr_o), .xmove_busy_o(xmove_busy_o),
    .xmove_done_o(xmove_done_o), .cycle_adv_o(cycle_adv_o), .ale_enable_o(ale_enable_o),
    .port_latch_o(port_latch_o), .stack_ptr_o(stack_ptr_o));

// ---- tb/cspc_xmem_model.sv ----
// external data memory stand-in that logs each move address
`timescale 1ns/1ps
module cspc_xmem_model (
    input wire clk_i,
    input wire reset_n_i,
    input wire [15:0] addr_i,
    input wire done_i,
    output reg [15:0] last_addr_o,
    output reg [7:0] moves_o
);
    // latch on the last cycle, when a slow memory would finish its access
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            last_addr_o <= 16'h0000;
            moves_o <= 8'h00;
        end else if (done_i) begin
            last_addr_o <= addr_i;
            moves_o <= moves_o + 8'h01;
        end
    end
endmodule
